// *** shared/pcmc_defines.svh ***
// Offsets, field positions, reset values and counts of the power and clock-mode control.
// Assumes a 12-bit AXI4-Lite byte address; each register sits at four times its index.
`ifndef PCMC_DEFINES_SVH
`define PCMC_DEFINES_SVH

`define PCMC_IDX_PWR 10'h087
`define PCMC_IDX_EXF 10'h091
`define PCMC_IDX_PMR 10'h0c4
`define PCMC_IDX_STS 10'h0c5
`define PCMC_ADDR_PWR {`PCMC_IDX_PWR, 2'b00}
`define PCMC_ADDR_EXF {`PCMC_IDX_EXF, 2'b00}
`define PCMC_ADDR_PMR {`PCMC_IDX_PMR, 2'b00}
`define PCMC_ADDR_STS {`PCMC_IDX_STS, 2'b00}

`define PCMC_PWR_IDLE 0
`define PCMC_PWR_STOP 1
`define PCMC_EXF_SRC 3
`define PCMC_EXF_RING 2
`define PCMC_EXF_FAST 1
`define PCMC_EXF_REF 0
`define PCMC_PMR_DIV_HI 7
`define PCMC_PMR_DIV_LO 6
`define PCMC_PMR_AUTO 5
`define PCMC_PMR_XOFF 3
`define PCMC_PMR_QUIET 2

`define PCMC_DIV_FULL 2'h1
`define PCMC_DIV_RED1 2'h2
`define PCMC_DIV_RED2 2'h3
`define PCMC_RST_DIV 2'h1
`define PCMC_RST_SRC 1'b1
`define PCMC_RST_XRDY 1'b1
`define PCMC_TERM_FULL 10'h003
`define PCMC_TERM_RED1 10'h03f
`define PCMC_TERM_RED2 10'h3ff

`define PCMC_XTAL_WARMUP 65536
`define PCMC_RESP_OKAY 2'h0
`define PCMC_RESP_SLVERR 2'h2

`endif

// *** shared/pcmc_pkg.sv ***
// Types shared by the power and clock-mode control.
// Numbers live in pcmc_defines.svh.
package pcmc_pkg;
	typedef enum logic [1:0] {PCMC_RUN, PCMC_IDLE, PCMC_STOP, PCMC_WAKE} pcmc_mode_e;
	typedef logic [1:0] pcmc_div_t;
endpackage

// *** verif/pcmc_ctrl_sva.sv ***
// Checker for pcmc_ctrl: bus handshakes, stop gating, divider tick spacing, strobe shape.
// Assumes it is bound to pcmc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module pcmc_ctrl_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_irq_wake,
	input wire logic powerfail_event,
	input wire logic core_clk_en,
	input wire logic crystal_amp_en,
	input wire logic ring_osc_en,
	input wire logic ring_clock_sel,
	input wire logic [1:0] cycle_div,
	input wire logic cycle_tick,
	input wire logic reference_on,
	input wire logic addr_strobe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("no write response");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_stop_quiet: assert property (!core_clk_en |-> !crystal_amp_en && !ring_osc_en && !addr_strobe)
		else $error("clocks alive in stop");
	a_stop_exit_only: assert property (!core_clk_en && !ext_irq_wake && !powerfail_event |=> !core_clk_en)
		else $error("stop left without wake");
	a_ref_awake: assert property (core_clk_en |-> reference_on)
		else $error("reference off outside stop");
	a_ring_osc_use: assert property (ring_osc_en == (ring_clock_sel && core_clk_en))
		else $error("ring enable mismatch");
	a_div_legal: assert property (cycle_div != 2'h0)
		else $error("reserved divider");
	a_tick_gap: assert property (cycle_tick && cycle_div == 2'h1 |=> !cycle_tick [*3])
		else $error("tick too soon");
	a_strobe_shape: assert property ($rose(addr_strobe) |-> ##2 !addr_strobe)
		else $error("strobe high too long");
	c_div_slow: cover property (cycle_div == 2'h3);
	c_ring_on: cover property ($rose(ring_clock_sel));
	c_stop_in: cover property ($fell(core_clk_en));
endmodule
bind pcmc_ctrl pcmc_ctrl_sva pcmc_ctrl_sva_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ext_irq_wake, .powerfail_event,
	.core_clk_en, .crystal_amp_en, .ring_osc_en, .ring_clock_sel, .cycle_div, .cycle_tick,
	.reference_on, .addr_strobe);

// *** verif/test_power_clock_mode_control.sv ***
// Testbench for pcmc_ctrl: register access over AXI4-Lite, modes, divider, source, strobe.
// Assumes short warm-up counts of 16 and aclk standing in for the crystal clock.
`timescale 1ns/1ps
`include "pcmc_defines.svh"
module test_power_clock_mode_control;
	logic aclk = 0, aresetn = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic crystal_osc_ok = 1, external_data_move = 0;
	logic [5:0] ev = 0;
	logic [7:0] st = 0, k;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, cycle_div;
	wire [31:0] s_axi_rdata;
	wire cpu_run, core_clk_en, crystal_amp_en, ring_osc_en, ring_clock_sel, cycle_tick, reference_on, addr_strobe;
	int bad_count = 0, check_count = 0, cycles = 0;
	localparam logic [11:0] PWR = `PCMC_ADDR_PWR, EXF = `PCMC_ADDR_EXF, POWER_MODE_REG = `PCMC_ADDR_PMR, STS = `PCMC_ADDR_STS;
	localparam logic [1:0] OK = `PCMC_RESP_OKAY, ERR = `PCMC_RESP_SLVERR;
	pcmc_ctrl #(.XTAL_WARMUP(16), .RING_WAKE_LEN(16)) pcmc_ctrl_i (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.crystal_osc_ok, .irq_any(ev[0]), .ext_irq_wake(ev[1]), .ext_irq_serviceable(ev[2]),
		.serial_start_detect(ev[3]), .serial_tx_write(ev[4]), .powerfail_event(ev[5]),
		.powerfail_level_active(st[7]), .upper_level_active(st[6]), .lower_level_active(st[5]),
		.port1_tx_busy(st[3]), .port1_rx_busy(st[2]), .port0_tx_busy(st[1]), .port0_rx_busy(st[0]),
		.external_data_move, .cpu_run, .core_clk_en, .crystal_amp_en, .ring_osc_en,
		.ring_clock_sel, .cycle_div, .cycle_tick, .reference_on, .addr_strobe);
	initial forever #10 aclk = ~aclk;
	task final_report;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 10000) begin
			bad_count++;
			final_report;
		end
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task te(input string s);
		$display("test %s done", s);
	endtask
	// Ends on a falling edge so outputs of the last edge have settled
	task cyc(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask
	task pz(input int i);
		@(posedge aclk);
		ev[i] <= 1'b1;
		@(posedge aclk);
		ev[i] <= 1'b0;
		@(negedge aclk);
	endtask
	// Ready already stands high before the request; values read at an edge are those that stood before it
	task automatic wk(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask
	task automatic rk(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata[7:0], e);
		chk(s_axi_rresp, er);
	endtask
	// Counts cycle ticks over n settled samples
	task automatic ct(input int n, output logic [7:0] t);
		t = 0;
		repeat (n) begin
			@(negedge aclk);
			if (cycle_tick) t++;
		end
	endtask
	task automatic cr(input logic mv, output logic [7:0] n);
		logic p;
		@(posedge aclk);
		external_data_move <= mv;
		n = 0;
		// One edge for the new move level to reach the strobe
		@(posedge aclk);
		@(negedge aclk);
		p = addr_strobe;
		repeat (40) begin
			@(negedge aclk);
			if (addr_strobe && !p) n++;
			p = addr_strobe;
		end
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rk(PWR, 8'h00, OK);
		rk(EXF, 8'h08, OK);
		rk(POWER_MODE_REG, 8'h40, OK);
		rk(STS, 8'h10, OK);
		rk(12'h000, 8'h00, ERR);
		wk(12'h004, 8'hff, ERR);
		s_axi_wstrb <= 4'he;
		wk(POWER_MODE_REG, 8'h80, OK);
		s_axi_wstrb <= 4'hf;
		rk(POWER_MODE_REG, 8'h40, OK);
		st <= 8'hef;
		rk(STS, 8'hff, OK);
		st <= 8'h4a;
		rk(STS, 8'h5a, OK);
		st <= 8'h00;
		te("reset and status");
		ct(40, k);
		chk(k, 8'd10);
		wk(POWER_MODE_REG, 8'h80, OK);
		cyc(8);
		chk(cycle_div, 2'h2);
		ct(128, k);
		chk(k, 8'd2);
		wk(POWER_MODE_REG, 8'hc0, OK);
		rk(POWER_MODE_REG, 8'h80, OK);
		wk(POWER_MODE_REG, 8'h00, OK);
		rk(POWER_MODE_REG, 8'h80, OK);
		wk(POWER_MODE_REG, 8'h40, OK);
		cyc(70);
		chk(cycle_div, 2'h1);
		wk(POWER_MODE_REG, 8'hc0, OK);
		cyc(8);
		chk(cycle_div, 2'h3);
		ct(2048, k);
		chk(k, 8'd2);
		wk(POWER_MODE_REG, 8'he0, OK);
		rk(POWER_MODE_REG, 8'he0, OK);
		pz(4);
		chk(cycle_div, 2'h1);
		rk(POWER_MODE_REG, 8'h60, OK);
		for (int i = 2; i < 5; i++) begin
			wk(POWER_MODE_REG, 8'ha0, OK);
			pz(i);
			rk(POWER_MODE_REG, 8'h60, OK);
		end
		wk(POWER_MODE_REG, 8'h80, OK);
		pz(4);
		rk(POWER_MODE_REG, 8'h80, OK);
		wk(POWER_MODE_REG, 8'h40, OK);
		cyc(70);
		te("divider");
		wk(EXF, 8'h00, OK);
		cyc(8);
		chk(ring_clock_sel, 1'b1);
		chk(ring_osc_en, 1'b1);
		rk(EXF, 8'h04, OK);
		wk(POWER_MODE_REG, 8'h48, OK);
		cyc(1);
		chk(crystal_amp_en, 1'b0);
		rk(STS, 8'h00, OK);
		wk(EXF, 8'h08, OK);
		rk(EXF, 8'h04, OK);
		wk(POWER_MODE_REG, 8'he8, OK);
		pz(3);
		rk(POWER_MODE_REG, 8'h68, OK);
		rk(EXF, 8'h04, OK);
		crystal_osc_ok <= 1'b0;
		wk(POWER_MODE_REG, 8'h40, OK);
		rk(STS, 8'h00, OK);
		cyc(30);
		rk(STS, 8'h00, OK);
		crystal_osc_ok <= 1'b1;
		cyc(30);
		rk(STS, 8'h10, OK);
		wk(EXF, 8'h08, OK);
		cyc(8);
		chk(ring_clock_sel, 1'b0);
		wk(POWER_MODE_REG, 8'h48, OK);
		rk(POWER_MODE_REG, 8'h40, OK);
		te("clock source");
		wk(PWR, 8'h01, OK);
		cyc(2);
		chk(cpu_run, 1'b0);
		chk(core_clk_en, 1'b1);
		pz(0);
		chk(cpu_run, 1'b1);
		wk(PWR, 8'h02, OK);
		cyc(2);
		chk(core_clk_en, 1'b0);
		chk(reference_on, 1'b0);
		pz(0);
		pz(4);
		pz(5);
		chk(core_clk_en, 1'b0);
		pz(1);
		chk(core_clk_en, 1'b1);
		chk(ring_clock_sel, 1'b0);
		cyc(30);
		chk(cpu_run, 1'b1);
		wk(EXF, 8'h09, OK);
		wk(PWR, 8'h02, OK);
		cyc(2);
		chk(reference_on, 1'b1);
		pz(5);
		chk(core_clk_en, 1'b1);
		cyc(30);
		wk(EXF, 8'h0a, OK);
		wk(PWR, 8'h02, OK);
		cyc(2);
		pz(1);
		chk(cpu_run, 1'b1);
		chk(ring_clock_sel, 1'b1);
		chk(ring_osc_en, 1'b1);
		rk(EXF, 8'h0e, OK);
		cyc(30);
		chk(ring_clock_sel, 1'b0);
		rk(EXF, 8'h0a, OK);
		te("idle and stop");
		cr(1'b0, k);
		chk(k, 8'd10);
		wk(POWER_MODE_REG, 8'h44, OK);
		cr(1'b0, k);
		chk(k, 8'd0);
		cr(1'b1, k);
		chk(k, 8'd10);
		te("strobe");
		final_report;
	end
endmodule

// *** verilog/pcmc_ctrl.sv ***
// Power and clock-mode control: divider, clock source, Idle/Stop, strobe, AXI4-Lite registers.
// Assumes one clock aclk that counts as the crystal clock; event inputs come from same-clock
// logic, crystal_osc_ok comes from the analog oscillator detector and is synchronised here.
// Functional notes
// - Source bit 1 picks crystal, 0 ring; 0-to-1 needs crystal ready and amplifier on.
// - Ring-active flag reads 1 while running on ring, 0 on crystal; resets 0.
// - Divider field 01 is 4 clocks, 10 is 64, 11 is 1024; resets 01.
// - Divider accepts 10 or 11 only while it holds 01.
// - Auto-restore bit enables hardware return to 4 clocks; resets 0, freely writable.
// - Crystal-disable bit stops amplifier; settable only while ring is selected; resets 0.
// - Three read-only flags show power-fail, upper and lower level in service.
// - Crystal-ready flag reads 1 once crystal is stable; resets 1.
// - Four read-only serial activity flags, port 1 in bits 3:2, port 0 in 1:0.
// - Power control bit 0 enters Idle; CPU stops, clocks and peripherals run.
// - Idle ends on any interrupt or on reset.
// - Power control bit 1 enters Stop, halting all clocks including crystal.
// - Stop ends only on external interrupt, power-fail while reference-keep is set, or reset condition.
// - Reference-keep bit holds reference on in Stop so power-fail can wake.
// - Fast-wake bit makes a Stop exit run on ring immediately.
// - After ring wake, switch to crystal after 65536 crystal clocks.
// - Ring-active flag stays 1 throughout the ring-clocked wake period.
// - Strobe-quiet keeps address strobe static except during external data moves.
// - Strobe-quiet resets 0; then strobe toggles at a quarter of crystal rate.
// - Auto-restore fires on serviceable external irq, start bit, or transmit write.
// - Crystal ready is set 65536 clocks after amplifier enable and oscillator start.
// - Divider and source changes take effect at the end of the instruction cycle in which they are written.
// - Auto-restore changes only divider speed, never the clock source.
`timescale 1ns/1ps
`include "pcmc_defines.svh"

module pcmc_ctrl
	import pcmc_pkg::*;
#(
	parameter int XTAL_WARMUP = `PCMC_XTAL_WARMUP,
	parameter int RING_WAKE_LEN = `PCMC_XTAL_WARMUP
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic crystal_osc_ok,
	input wire logic irq_any,
	input wire logic ext_irq_wake,
	input wire logic ext_irq_serviceable,
	input wire logic serial_start_detect,
	input wire logic serial_tx_write,
	input wire logic powerfail_event,
	input wire logic powerfail_level_active,
	input wire logic upper_level_active,
	input wire logic lower_level_active,
	input wire logic port1_tx_busy,
	input wire logic port1_rx_busy,
	input wire logic port0_tx_busy,
	input wire logic port0_rx_busy,
	input wire logic external_data_move,
	output logic cpu_run,
	output logic core_clk_en,
	output logic crystal_amp_en,
	output logic ring_osc_en,
	output logic ring_clock_sel,
	output logic [1:0] cycle_div,
	output logic cycle_tick,
	output logic reference_on,
	output logic addr_strobe
);

	localparam logic [16:0] WARM_LAST = 17'(XTAL_WARMUP - 1);
	localparam logic [16:0] WAKE_LAST = 17'(RING_WAKE_LEN - 1);
	pcmc_mode_e mode_r;
	pcmc_div_t div_r;
	pcmc_div_t div_eff_r;
	logic src_sel_r;
	logic src_eff_r;
	logic fast_wake_r;
	logic ref_keep_r;
	logic auto_r;
	logic xtal_off_r;
	logic quiet_r;
	logic xtal_ready_r;
	logic [16:0] warm_cnt_r;
	logic ring_wake_r;
	logic [16:0] wake_cnt_r;
	logic [9:0] cyc_cnt_r;
	logic [1:0] phase_r;
	logic strobe_r;
	logic osc_s1_r;
	logic osc_s2_r;
	logic aw_hold_r;
	logic w_hold_r;
	logic [11:0] awaddr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [7:0] rdata_r;
	logic [1:0] rresp_r;
	logic wr_en;
	logic wr_pwr;
	logic wr_exf;
	logic wr_pmr;
	logic wr_hit;
	logic ar_take;
	logic restore_evt;
	logic stop_wake;
	logic tick;
	logic ring_flag;
	logic [9:0] term;
	pcmc_div_t div_wr;
	// Write happens once both halves are held, byte lane 0 is strobed and the response slot is free
	assign wr_en = aw_hold_r && w_hold_r && !bvalid_r && wlane_r;
	assign wr_pwr = wr_en && (awaddr_r == `PCMC_ADDR_PWR);
	assign wr_exf = wr_en && (awaddr_r == `PCMC_ADDR_EXF);
	assign wr_pmr = wr_en && (awaddr_r == `PCMC_ADDR_PMR);
	assign wr_hit = (awaddr_r == `PCMC_ADDR_PWR) || (awaddr_r == `PCMC_ADDR_EXF) ||
		(awaddr_r == `PCMC_ADDR_PMR) || (awaddr_r == `PCMC_ADDR_STS);
	assign ar_take = s_axi_arvalid && !rvalid_r;
	assign div_wr = wbyte_r[`PCMC_PMR_DIV_HI:`PCMC_PMR_DIV_LO];
	assign restore_evt = auto_r && (ext_irq_serviceable || serial_start_detect ||
		serial_tx_write);
	assign stop_wake = ext_irq_wake || (ref_keep_r && powerfail_event);
	assign ring_flag = !src_eff_r || ring_wake_r;
	always_comb begin
		case (div_eff_r)
			`PCMC_DIV_RED1: term = `PCMC_TERM_RED1;
			`PCMC_DIV_RED2: term = `PCMC_TERM_RED2;
			default: term = `PCMC_TERM_FULL;
		endcase
	end
	assign tick = (mode_r != PCMC_STOP) && (cyc_cnt_r == term);
	// Oscillator detector is asynchronous to aclk
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
		end else begin
			osc_s1_r <= crystal_osc_ok;
			osc_s2_r <= osc_s1_r;
		end
	end

	// Power mode sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= PCMC_RUN;
		end else begin
			case (mode_r)
				PCMC_RUN: begin
					if (wr_pwr && wbyte_r[`PCMC_PWR_STOP]) begin
						mode_r <= PCMC_STOP;
					end else if (wr_pwr && wbyte_r[`PCMC_PWR_IDLE]) begin
						mode_r <= PCMC_IDLE;
					end
				end
				PCMC_IDLE: begin
					if (irq_any) begin
						mode_r <= PCMC_RUN;
					end
				end
				PCMC_STOP: begin
					if (stop_wake) begin
						mode_r <= fast_wake_r ? PCMC_RUN : PCMC_WAKE;
					end
				end
				PCMC_WAKE: begin
					// Without the ring the CPU waits out the crystal warm-up
					if (xtal_ready_r || !src_sel_r) begin
						mode_r <= PCMC_RUN;
					end
				end
				default: mode_r <= PCMC_RUN;
			endcase
		end
	end

	// Clock source, fast-wake and reference control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_sel_r <= `PCMC_RST_SRC;
			fast_wake_r <= 1'b0;
			ref_keep_r <= 1'b0;
		end else if (wr_exf) begin
			fast_wake_r <= wbyte_r[`PCMC_EXF_FAST];
			ref_keep_r <= wbyte_r[`PCMC_EXF_REF];
			if (!wbyte_r[`PCMC_EXF_SRC]) begin
				src_sel_r <= 1'b0;
			end else if (xtal_ready_r && !xtal_off_r) begin
				src_sel_r <= 1'b1;
			end
		end
	end

	// Divider field; restore wins over a same-cycle write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_r <= `PCMC_RST_DIV;
		end else if (restore_evt) begin
			div_r <= `PCMC_DIV_FULL;
		end else if (wr_pmr) begin
			if (div_wr == `PCMC_DIV_FULL) begin
				div_r <= div_wr;
			end else if (div_wr != 2'h0 && div_r == `PCMC_DIV_FULL) begin
				div_r <= div_wr;
			end
		end
	end

	// Remaining mode bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			auto_r <= 1'b0;
			xtal_off_r <= 1'b0;
			quiet_r <= 1'b0;
		end else if (wr_pmr) begin
			auto_r <= wbyte_r[`PCMC_PMR_AUTO];
			quiet_r <= wbyte_r[`PCMC_PMR_QUIET];
			if (!wbyte_r[`PCMC_PMR_XOFF] || !src_sel_r) begin
				xtal_off_r <= wbyte_r[`PCMC_PMR_XOFF];
			end
		end
	end

	// Crystal warm-up after amplifier enable, only once oscillation is seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xtal_ready_r <= `PCMC_RST_XRDY;
			warm_cnt_r <= 17'h00000;
		end else if (xtal_off_r || mode_r == PCMC_STOP) begin
			xtal_ready_r <= 1'b0;
			warm_cnt_r <= 17'h00000;
		end else if (!xtal_ready_r && osc_s2_r) begin
			if (warm_cnt_r == WARM_LAST) begin
				xtal_ready_r <= 1'b1;
				warm_cnt_r <= 17'h00000;
			end else begin
				warm_cnt_r <= warm_cnt_r + 17'h00001;
			end
		end
	end

	// Ring-clocked period after a fast wake from Stop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ring_wake_r <= 1'b0;
			wake_cnt_r <= 17'h00000;
		end else if (mode_r == PCMC_STOP) begin
			ring_wake_r <= stop_wake && fast_wake_r;
			wake_cnt_r <= 17'h00000;
		end else if (ring_wake_r) begin
			// Counts crystal clocks, so it only advances once the crystal oscillates
			if (osc_s2_r) begin
				if (wake_cnt_r == WAKE_LAST) begin
					ring_wake_r <= 1'b0;
					wake_cnt_r <= 17'h00000;
				end else begin
					wake_cnt_r <= wake_cnt_r + 17'h00001;
				end
			end
		end
	end

	// Instruction cycle counter; new divider and source load at cycle end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_cnt_r <= 10'h000;
			div_eff_r <= `PCMC_RST_DIV;
			src_eff_r <= `PCMC_RST_SRC;
		end else if (restore_evt) begin
			// Restore is immediate so a start bit still sees the right baud rate
			cyc_cnt_r <= 10'h000;
			div_eff_r <= `PCMC_DIV_FULL;
		end else if (tick) begin
			cyc_cnt_r <= 10'h000;
			div_eff_r <= div_r;
			src_eff_r <= src_sel_r;
		end else if (mode_r != PCMC_STOP) begin
			cyc_cnt_r <= cyc_cnt_r + 10'h001;
		end
	end

	// Address strobe, one quarter of the crystal rate; dropped on Stop entry so it never outlives the clocks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_r <= 2'h0;
			strobe_r <= 1'b0;
		end else if (mode_r == PCMC_STOP || (wr_pwr && wbyte_r[`PCMC_PWR_STOP] && mode_r == PCMC_RUN)) begin
			phase_r <= 2'h0;
			strobe_r <= 1'b0;
		end else begin
			phase_r <= phase_r + 2'h1;
			strobe_r <= phase_r[1] && (!quiet_r || external_data_move);
		end
	end

	// AXI4-Lite write channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			awaddr_r <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end else if (aw_hold_r && w_hold_r && !bvalid_r) begin
			aw_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_r <= 1'b0;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_r <= 1'b1;
			wbyte_r <= s_axi_wdata[7:0];
			wlane_r <= s_axi_wstrb[0];
		end else if (aw_hold_r && w_hold_r && !bvalid_r) begin
			w_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `PCMC_RESP_OKAY;
		end else if (aw_hold_r && w_hold_r && !bvalid_r) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? `PCMC_RESP_OKAY : `PCMC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// AXI4-Lite read; unmapped addresses answer zero with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 8'h00;
			rresp_r <= `PCMC_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rresp_r <= `PCMC_RESP_OKAY;
			case (s_axi_araddr)
				`PCMC_ADDR_PWR: rdata_r <= {6'h00, mode_r == PCMC_STOP, mode_r == PCMC_IDLE};
				`PCMC_ADDR_EXF: rdata_r <= {4'h0, src_sel_r, ring_flag, fast_wake_r, ref_keep_r};
				`PCMC_ADDR_PMR: rdata_r <= {div_r, auto_r, 1'b0, xtal_off_r, quiet_r, 2'h0};
				`PCMC_ADDR_STS: rdata_r <= {powerfail_level_active, upper_level_active,
					lower_level_active, xtal_ready_r, port1_tx_busy, port1_rx_busy,
					port0_tx_busy, port0_rx_busy};
				default: begin
					rdata_r <= 8'h00;
					rresp_r <= `PCMC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = {24'h000000, rdata_r};

	assign cpu_run = (mode_r == PCMC_RUN);
	assign core_clk_en = (mode_r != PCMC_STOP);
	assign crystal_amp_en = !xtal_off_r && (mode_r != PCMC_STOP);
	assign ring_clock_sel = ring_flag;
	assign ring_osc_en = ring_flag && (mode_r != PCMC_STOP);
	assign cycle_div = div_eff_r;
	assign cycle_tick = tick;
	// Reference only drops in Stop, and only when not asked to stay on
	assign reference_on = (mode_r != PCMC_STOP) || ref_keep_r;
	assign addr_strobe = strobe_r;

endmodule
